/* File: core/crtvx_pkg.sv */
// crtvx package: register indices, field positions, reset values and carrier types
package crtvx_pkg;

    // crt controller indices of registers held in this block
    localparam logic [7:0] IDX_VERT_TOTAL_LOW = 8'h06;
    localparam logic [7:0] IDX_OVERFLOW = 8'h07;
    localparam logic [7:0] IDX_MAX_SCAN_LINE = 8'h09;
    localparam logic [7:0] IDX_START_ADDR_MID = 8'h0C;
    localparam logic [7:0] IDX_START_ADDR_LOW = 8'h0D;
    localparam logic [7:0] IDX_VERT_SYNC_START_LOW = 8'h10;
    localparam logic [7:0] IDX_VERT_DISPLAY_END_LOW = 8'h12;
    localparam logic [7:0] IDX_ROW_OFFSET_LOW = 8'h13;
    localparam logic [7:0] IDX_VERT_BLANK_START_LOW = 8'h15;
    localparam logic [7:0] IDX_EXT_VERT_TOTAL_HIGH = 8'h30;
    localparam logic [7:0] IDX_EXT_VERT_DISPLAY_END_HIGH = 8'h31;
    localparam logic [7:0] IDX_EXT_VERT_SYNC_START_HIGH = 8'h32;
    localparam logic [7:0] IDX_EXT_VERT_BLANK_START_HIGH = 8'h33;
    localparam logic [7:0] IDX_EXT_START_ADDRESS_HIGH = 8'h40;
    localparam logic [7:0] IDX_EXT_ROW_OFFSET_HIGH = 8'h41;

    // field positions
    localparam int OVF_VERT_TOTAL_B8 = 0;
    localparam int OVF_DISPLAY_END_B8 = 1;
    localparam int OVF_SYNC_START_B8 = 2;
    localparam int OVF_BLANK_START_B8 = 3;
    localparam int OVF_VERT_TOTAL_B9 = 5;
    localparam int OVF_DISPLAY_END_B9 = 6;
    localparam int OVF_SYNC_START_B9 = 7;
    localparam int MSL_BLANK_START_B9 = 5;
    localparam int EXT_SA_UPDATE_REQ_BIT = 7;
    localparam int IOCTL_EXT_MODE_BIT = 0;
    localparam int CLKMODE_DWORD_BIT = 2;

    // reset values
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [11:0] LINE_RESET = 12'h000;
    localparam logic [19:0] START_RESET = 20'h00000;
    localparam logic [13:0] STRIDE_RESET = 14'h0000;

    // host access on the indexed i/o ports; sel low is the index port
    typedef struct packed {
        logic rd;
        logic wr;
        logic sel;
        logic [7:0] wdata;
    } crtvx_io_t;

    // composed timing and addressing values
    typedef struct packed {
        logic [11:0] vert_total;
        logic [11:0] display_end;
        logic [11:0] sync_start;
        logic [11:0] blank_start;
        logic [11:0] row_offset;
    } crtvx_timing_t;

endpackage

/* File: core/crtvx_regs.sv */
// crtvx_regs: crt vertical extension registers, line counter and start address double buffer
`timescale 1ns/100ps

module crtvx_regs (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // indexed i/o port access
    input wire crtvx_pkg::crtvx_io_t io_req,
    output logic [7:0] io_rdata,
    output logic io_rack,
    // mode inputs from other register groups
    input wire logic [7:0] io_control_reg,
    input wire logic [7:0] clocking_mode_reg,
    // horizontal timing
    input wire logic line_end,
    // vertical timing outputs
    output logic [11:0] scan_line,
    output logic disp_en,
    output logic vsync_start,
    output logic vblank,
    // addressing outputs
    output logic [19:0] start_addr,
    output logic [11:0] row_offset,
    output logic [13:0] row_stride_bytes,
    output logic ext_mode
);

    // compose a 10-bit or 12-bit value from its parts
    function automatic logic [11:0] compose(input logic ext, input logic [7:0] hi,
                                             input logic b9, input logic b8,
                                             input logic [7:0] low);
        logic [11:0] v;
        if (ext) begin
            v = {hi[3:0], low};
        end else begin
            v = {2'b00, b9, b8, low};
        end
        return v;
    endfunction

    // start address from its high nibble and the two base bytes
    function automatic logic [19:0] start_of(input logic [3:0] hi, input logic [7:0] mid,
                                             input logic [7:0] low);
        return {hi, mid, low};
    endfunction

    // register file state
    logic [7:0] index;
    logic [7:0] vt_low, overflow, max_scan, sa_mid, sa_low;
    logic [7:0] vss_low, vde_low, ofs_low, vbs_low;
    logic [7:0] ext_vt, ext_vde, ext_vss, ext_vbs, ext_sa, ext_ofs;
    logic [7:0] next_index;
    logic [7:0] next_vt_low, next_overflow, next_max_scan, next_sa_mid, next_sa_low;
    logic [7:0] next_vss_low, next_vde_low, next_ofs_low, next_vbs_low;
    logic [7:0] next_ext_vt, next_ext_vde, next_ext_vss, next_ext_vbs;
    logic [7:0] next_ext_sa, next_ext_ofs;
    logic [7:0] next_io_rdata;
    logic next_io_rack;

    // timing state
    logic [11:0] next_scan_line;
    logic next_disp_en, next_vsync_start, next_vblank, next_ext_mode;
    logic [19:0] next_start_addr;
    logic [11:0] next_row_offset;
    logic [13:0] next_row_stride_bytes;

    // combinational helpers
    crtvx_pkg::crtvx_timing_t tim;
    logic ext;
    logic data_wr;
    logic [11:0] line_inc;
    logic [12:0] last_line;
    logic sync_hit;
    logic transfer;

    // mode is live: a width change reaches the compares at the next line_end
    assign ext = io_control_reg[crtvx_pkg::IOCTL_EXT_MODE_BIT];
    assign data_wr = io_req.wr & io_req.sel;

    // composed values, recomputed every cycle from the live registers
    always_comb begin
        tim.vert_total = compose(ext, ext_vt, overflow[crtvx_pkg::OVF_VERT_TOTAL_B9],
                                 overflow[crtvx_pkg::OVF_VERT_TOTAL_B8], vt_low);
        tim.display_end = compose(ext, ext_vde, overflow[crtvx_pkg::OVF_DISPLAY_END_B9],
                                  overflow[crtvx_pkg::OVF_DISPLAY_END_B8], vde_low);
        tim.sync_start = compose(ext, ext_vss, overflow[crtvx_pkg::OVF_SYNC_START_B9],
                                 overflow[crtvx_pkg::OVF_SYNC_START_B8], vss_low);
        tim.blank_start = compose(ext, ext_vbs, max_scan[crtvx_pkg::MSL_BLANK_START_B9],
                                  overflow[crtvx_pkg::OVF_BLANK_START_B8], vbs_low);
        if (ext) begin
            tim.row_offset = {ext_ofs[3:0], ofs_low};
        end else begin
            tim.row_offset = {4'h0, ofs_low};
        end
    end

    // register writes and reads over the index and data ports
    always_comb begin
        next_index = index;
        next_vt_low = vt_low;
        next_overflow = overflow;
        next_max_scan = max_scan;
        next_sa_mid = sa_mid;
        next_sa_low = sa_low;
        next_vss_low = vss_low;
        next_vde_low = vde_low;
        next_ofs_low = ofs_low;
        next_vbs_low = vbs_low;
        next_ext_vt = ext_vt;
        next_ext_vde = ext_vde;
        next_ext_vss = ext_vss;
        next_ext_vbs = ext_vbs;
        next_ext_sa = ext_sa;
        next_ext_ofs = ext_ofs;
        // hardware clear first so a same-cycle software write wins
        if (transfer) begin
            next_ext_sa[crtvx_pkg::EXT_SA_UPDATE_REQ_BIT] = 1'b0;
        end
        if (io_req.wr && !io_req.sel) begin
            next_index = io_req.wdata;
        end
        if (data_wr) begin
            // reserved bits are stored as written; software keeps them zero
            // unmapped indices fall to the default branch and are dropped
            case (index)
                crtvx_pkg::IDX_VERT_TOTAL_LOW: next_vt_low = io_req.wdata;
                crtvx_pkg::IDX_OVERFLOW: next_overflow = io_req.wdata;
                crtvx_pkg::IDX_MAX_SCAN_LINE: next_max_scan = io_req.wdata;
                crtvx_pkg::IDX_START_ADDR_MID: next_sa_mid = io_req.wdata;
                crtvx_pkg::IDX_START_ADDR_LOW: next_sa_low = io_req.wdata;
                crtvx_pkg::IDX_VERT_SYNC_START_LOW: next_vss_low = io_req.wdata;
                crtvx_pkg::IDX_VERT_DISPLAY_END_LOW: next_vde_low = io_req.wdata;
                crtvx_pkg::IDX_ROW_OFFSET_LOW: next_ofs_low = io_req.wdata;
                crtvx_pkg::IDX_VERT_BLANK_START_LOW: next_vbs_low = io_req.wdata;
                crtvx_pkg::IDX_EXT_VERT_TOTAL_HIGH: next_ext_vt = io_req.wdata;
                crtvx_pkg::IDX_EXT_VERT_DISPLAY_END_HIGH: next_ext_vde = io_req.wdata;
                crtvx_pkg::IDX_EXT_VERT_SYNC_START_HIGH: next_ext_vss = io_req.wdata;
                crtvx_pkg::IDX_EXT_VERT_BLANK_START_HIGH: next_ext_vbs = io_req.wdata;
                crtvx_pkg::IDX_EXT_START_ADDRESS_HIGH: next_ext_sa = io_req.wdata;
                crtvx_pkg::IDX_EXT_ROW_OFFSET_HIGH: next_ext_ofs = io_req.wdata;
                default: next_index = index;
            endcase
        end
        // read data is zero outside a read, so outer read muxes can simply or
        next_io_rack = io_req.rd;
        next_io_rdata = 8'h00;
        if (io_req.rd && !io_req.sel) begin
            next_io_rdata = index;
        end else if (io_req.rd) begin
            case (index)
                crtvx_pkg::IDX_VERT_TOTAL_LOW: next_io_rdata = vt_low;
                crtvx_pkg::IDX_OVERFLOW: next_io_rdata = overflow;
                crtvx_pkg::IDX_MAX_SCAN_LINE: next_io_rdata = max_scan;
                crtvx_pkg::IDX_START_ADDR_MID: next_io_rdata = sa_mid;
                crtvx_pkg::IDX_START_ADDR_LOW: next_io_rdata = sa_low;
                crtvx_pkg::IDX_VERT_SYNC_START_LOW: next_io_rdata = vss_low;
                crtvx_pkg::IDX_VERT_DISPLAY_END_LOW: next_io_rdata = vde_low;
                crtvx_pkg::IDX_ROW_OFFSET_LOW: next_io_rdata = ofs_low;
                crtvx_pkg::IDX_VERT_BLANK_START_LOW: next_io_rdata = vbs_low;
                crtvx_pkg::IDX_EXT_VERT_TOTAL_HIGH: next_io_rdata = ext_vt;
                crtvx_pkg::IDX_EXT_VERT_DISPLAY_END_HIGH: next_io_rdata = ext_vde;
                crtvx_pkg::IDX_EXT_VERT_SYNC_START_HIGH: next_io_rdata = ext_vss;
                crtvx_pkg::IDX_EXT_VERT_BLANK_START_HIGH: next_io_rdata = ext_vbs;
                crtvx_pkg::IDX_EXT_START_ADDRESS_HIGH: next_io_rdata = ext_sa;
                crtvx_pkg::IDX_EXT_ROW_OFFSET_HIGH: next_io_rdata = ext_ofs;
                default: next_io_rdata = 8'h00;
            endcase
        end
    end

    // every register clears to zero; the live mode input sets widths afresh
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            index <= crtvx_pkg::REG_RESET;
            vt_low <= crtvx_pkg::REG_RESET;
            overflow <= crtvx_pkg::REG_RESET;
            max_scan <= crtvx_pkg::REG_RESET;
            sa_mid <= crtvx_pkg::REG_RESET;
            sa_low <= crtvx_pkg::REG_RESET;
            vss_low <= crtvx_pkg::REG_RESET;
            vde_low <= crtvx_pkg::REG_RESET;
            ofs_low <= crtvx_pkg::REG_RESET;
            vbs_low <= crtvx_pkg::REG_RESET;
            ext_vt <= crtvx_pkg::REG_RESET;
            ext_vde <= crtvx_pkg::REG_RESET;
            ext_vss <= crtvx_pkg::REG_RESET;
            ext_vbs <= crtvx_pkg::REG_RESET;
            ext_sa <= crtvx_pkg::REG_RESET;
            ext_ofs <= crtvx_pkg::REG_RESET;
            io_rdata <= crtvx_pkg::REG_RESET;
            io_rack <= 1'b0;
        end else begin
            index <= next_index;
            vt_low <= next_vt_low;
            overflow <= next_overflow;
            max_scan <= next_max_scan;
            sa_mid <= next_sa_mid;
            sa_low <= next_sa_low;
            vss_low <= next_vss_low;
            vde_low <= next_vde_low;
            ofs_low <= next_ofs_low;
            vbs_low <= next_vbs_low;
            ext_vt <= next_ext_vt;
            ext_vde <= next_ext_vde;
            ext_vss <= next_ext_vss;
            ext_vbs <= next_ext_vbs;
            ext_sa <= next_ext_sa;
            ext_ofs <= next_ext_ofs;
            io_rdata <= next_io_rdata;
            io_rack <= next_io_rack;
        end
    end

    // line counter wraps after vertical total plus one, i.e. total lines = value + 2
    assign last_line = {1'b0, tim.vert_total} + 13'h0001;
    assign line_inc = ({1'b0, scan_line} >= last_line) ? 12'h000 : scan_line + 12'h001;
    assign sync_hit = line_end && (line_inc == tim.sync_start);
    // mid and low bytes are taken live at the sync edge, so they must be written first
    // the request bit is inert unless extended mode is on
    assign transfer = sync_hit && ext && ext_sa[crtvx_pkg::EXT_SA_UPDATE_REQ_BIT];

    always_comb begin
        next_scan_line = scan_line;
        next_disp_en = disp_en;
        next_vblank = vblank;
        // a one-cycle strobe; the sync width belongs to the base timing logic
        next_vsync_start = sync_hit;
        next_ext_mode = ext;
        if (line_end) begin
            next_scan_line = line_inc;
            next_disp_en = (line_inc <= tim.display_end);
            if (line_inc == tim.blank_start) begin
                next_vblank = 1'b1;
            end else if (line_inc == 12'h000) begin
                // blank end lives elsewhere; here it drops at frame wrap
                next_vblank = 1'b0;
            end
        end
        next_start_addr = start_addr;
        // entering extended mode keeps the last address until a requested transfer
        if (!ext) begin
            next_start_addr = start_of(4'h0, sa_mid, sa_low);
        end else if (transfer) begin
            next_start_addr = start_of(ext_sa[3:0], sa_mid, sa_low);
        end
        next_row_offset = tim.row_offset;
        // dword pitch is four bytes per unit, word pitch two
        if (clocking_mode_reg[crtvx_pkg::CLKMODE_DWORD_BIT]) begin
            next_row_stride_bytes = {tim.row_offset, 2'b00};
        end else begin
            next_row_stride_bytes = {1'b0, tim.row_offset, 1'b0};
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            scan_line <= crtvx_pkg::LINE_RESET;
            disp_en <= 1'b0;
            vsync_start <= 1'b0;
            vblank <= 1'b0;
            ext_mode <= 1'b0;
            start_addr <= crtvx_pkg::START_RESET;
            row_offset <= crtvx_pkg::LINE_RESET;
            row_stride_bytes <= crtvx_pkg::STRIDE_RESET;
        end else begin
            scan_line <= next_scan_line;
            disp_en <= next_disp_en;
            vsync_start <= next_vsync_start;
            vblank <= next_vblank;
            ext_mode <= next_ext_mode;
            start_addr <= next_start_addr;
            row_offset <= next_row_offset;
            row_stride_bytes <= next_row_stride_bytes;
        end
    end

endmodule

/* File: verif/crtvx_regs_checker.sv */
// crtvx_regs_checker: port-level assertions for the crt vertical extension registers
`timescale 1ns/100ps
module crtvx_regs_checker (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // host port
    input wire crtvx_pkg::crtvx_io_t io_req,
    input wire logic [7:0] io_rdata,
    input wire logic io_rack,
    // mode and line inputs
    input wire logic [7:0] io_control_reg,
    input wire logic [7:0] clocking_mode_reg,
    input wire logic line_end,
    // timing and addressing outputs
    input wire logic [11:0] scan_line,
    input wire logic disp_en,
    input wire logic vsync_start,
    input wire logic vblank,
    input wire logic [19:0] start_addr,
    input wire logic [11:0] row_offset,
    input wire logic [13:0] row_stride_bytes,
    input wire logic ext_mode
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    rack_follow_a: assert property (io_req.rd |=> io_rack)
        else $error("read not acknowledged next cycle");
    rack_only_a: assert property (!io_req.rd |=> !io_rack)
        else $error("acknowledge without read");
    mode_copy_a: assert property ($past(nrst) |-> ext_mode == $past(io_control_reg[0]))
        else $error("mode output not following control bit");
    line_move_a: assert property ($changed(scan_line) |-> $past(line_end))
        else $error("line counter moved without line end");
    vsync_cause_a: assert property (vsync_start |-> $past(line_end) && !$past(vsync_start))
        else $error("sync start pulse not tied to a line end");
    vblank_cause_a: assert property ($rose(vblank) |-> $past(line_end))
        else $error("blanking began between lines");
    line0_active_a: assert property ($past(line_end) && scan_line == 12'h000 |-> disp_en)
        else $error("line zero not active");
    std_offset_a: assert property (!ext_mode && !$past(ext_mode) |-> row_offset[11:8] == 4'h0)
        else $error("standard offset wider than eight bits");
    // only a sync start may move the active address once extended mode is settled
    ext_hold_a: assert property (ext_mode && $past(ext_mode) && $changed(start_addr) |-> vsync_start)
        else $error("extended start address changed off sync");
    stride_a: assert property ($stable(clocking_mode_reg) && $stable(row_offset) |->
        row_stride_bytes == (clocking_mode_reg[2] ? {row_offset, 2'b00} : {1'b0, row_offset, 1'b0}))
        else $error("row stride does not match offset units");

    ext_load_c: cover property (ext_mode && vsync_start && $changed(start_addr));
    wrap_c: cover property ($past(line_end) && scan_line == 12'h000);
    read_c: cover property (io_rack);
endmodule

bind crtvx_regs crtvx_regs_checker u_chk (.core_clk(core_clk), .nrst(nrst), .io_req(io_req),
    .io_rdata(io_rdata), .io_rack(io_rack), .io_control_reg(io_control_reg),
    .clocking_mode_reg(clocking_mode_reg), .line_end(line_end), .scan_line(scan_line),
    .disp_en(disp_en), .vsync_start(vsync_start), .vblank(vblank), .start_addr(start_addr),
    .row_offset(row_offset), .row_stride_bytes(row_stride_bytes), .ext_mode(ext_mode));

/* File: verif/crtvx_regs_tb.sv */
// crtvx_regs_tb: self-checking bench for the crt vertical extension registers
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module crtvx_regs_tb;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic line_end = 1'b0;
    crtvx_pkg::crtvx_io_t io_req = '0;
    logic [7:0] io_control_reg = 8'h00;
    logic [7:0] clocking_mode_reg = 8'h00;
    logic [7:0] io_rdata;
    logic io_rack, disp_en, vsync_start, vblank, ext_mode;
    logic [11:0] scan_line, row_offset;
    logic [13:0] row_stride_bytes;
    logic [19:0] start_addr;
    logic [19:0] exp_sa = 20'h00000;
    logic [7:0] rf [0:255];
    logic vb = 1'b0;
    int fails = 0;
    int n_tests = 0;
    int cur = 0;

    always #2.5 core_clk = ~core_clk;

    crtvx_regs u_dut (.core_clk(core_clk), .nrst(nrst), .io_req(io_req), .io_rdata(io_rdata),
        .io_rack(io_rack), .io_control_reg(io_control_reg),
        .clocking_mode_reg(clocking_mode_reg), .line_end(line_end), .scan_line(scan_line),
        .disp_en(disp_en), .vsync_start(vsync_start), .vblank(vblank), .start_addr(start_addr),
        .row_offset(row_offset), .row_stride_bytes(row_stride_bytes), .ext_mode(ext_mode));

    // expected composition from the bench's own copy of the registers
    function automatic logic [11:0] comp(logic [7:0] hi, logic b9, logic b8, logic [7:0] lo);
        return io_control_reg[0] ? {hi[3:0], lo} : {2'b00, b9, b8, lo};
    endfunction

    task automatic put(input logic sel, input logic [7:0] d);
        @(posedge core_clk);
        io_req <= {1'b0, 1'b1, sel, d};
    endtask

    task automatic wr(input logic [15:0] t);
        put(1'b0, t[15:8]);
        put(1'b1, t[7:0]);
        rf[t[15:8]] = t[7:0];
        @(posedge core_clk);
        io_req <= '0;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        put(1'b0, idx);
        @(posedge core_clk);
        io_req <= {1'b1, 1'b0, 1'b1, 8'h00};
        @(posedge core_clk);
        io_req <= '0;
        #1;
        `CHK("io_rack", 1'b1, io_rack)
        `CHK("io_rdata", e, io_rdata)
    endtask

    // one scan line: pulse line_end, then judge every timing and address output
    task automatic lines(input int n);
        logic [11:0] vt, de, ss, bs, off;
        repeat (n) begin
            vt = comp(rf[8'h30], rf[8'h07][5], rf[8'h07][0], rf[8'h06]);
            de = comp(rf[8'h31], rf[8'h07][6], rf[8'h07][1], rf[8'h12]);
            ss = comp(rf[8'h32], rf[8'h07][7], rf[8'h07][2], rf[8'h10]);
            bs = comp(rf[8'h33], rf[8'h09][5], rf[8'h07][3], rf[8'h15]);
            off = comp(rf[8'h41], 1'b0, 1'b0, rf[8'h13]);
            @(posedge core_clk);
            line_end <= 1'b1;
            @(posedge core_clk);
            line_end <= 1'b0;
            cur = (cur >= vt + 1) ? 0 : cur + 1;
            if (cur == 0) vb = 1'b0;
            if (cur == bs) vb = 1'b1;
            if (!io_control_reg[0]) exp_sa = {4'h0, rf[8'h0C], rf[8'h0D]};
            else if (rf[8'h40][7] && cur == ss) begin
                exp_sa = {rf[8'h40][3:0], rf[8'h0C], rf[8'h0D]};
                rf[8'h40][7] = 1'b0;
            end
            #1;
            `CHK("scan_line", cur[11:0], scan_line)
            `CHK("disp_en", (cur <= de), disp_en)
            `CHK("vsync_start", (cur == ss), vsync_start)
            `CHK("vblank", vb, vblank)
            `CHK("start_addr", exp_sa, start_addr)
            `CHK("row_offset", off, row_offset)
            `CHK("row_stride_bytes", (clocking_mode_reg[2] ? {off, 2'b00} : {1'b0, off, 1'b0}),
                row_stride_bytes)
            `CHK("ext_mode", io_control_reg[0], ext_mode)
        end
    endtask

    task automatic sc_regs();
        logic [7:0] ix [6] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h40, 8'h41};
        foreach (ix[i]) rd(ix[i], 8'h00);
        foreach (ix[i]) wr({ix[i], 8'h09 - 8'(i)});
        foreach (ix[i]) rd(ix[i], rf[ix[i]]);
        wr(16'h50FF);
        rd(8'h50, 8'h00);
    endtask

    // bit 9 paths first, then bit 8 paths; upper nibbles left set must be ignored
    task automatic sc_std();
        logic [15:0] t [9] = '{16'h0604, 16'h07E0, 16'h0920, 16'h1201, 16'h1003, 16'h1502,
            16'h1334, 16'h0C12, 16'h0D34};
        foreach (t[i]) wr(t[i]);
        lines(16'h0208);
        wr(16'h070F);
        wr(16'h0900);
        clocking_mode_reg <= 8'h04;
        lines(16'h0108);
    endtask

    task automatic sc_ext();
        logic [15:0] t [6] = '{16'h3001, 16'h3108, 16'h3201, 16'h3301, 16'h07FF, 16'h09FF};
        @(posedge core_clk);
        io_control_reg <= 8'h01;
        foreach (t[i]) wr(t[i]);
        lines(16'h0108);
    endtask

    task automatic sc_start();
        logic [15:0] t [10] = '{16'h3000, 16'h3100, 16'h3200, 16'h3300, 16'h060E, 16'h1205,
            16'h1007, 16'h1506, 16'h0C56, 16'h0D78};
        foreach (t[i]) wr(t[i]);
        wr(16'h400A);
        wr(16'h408A);
        rd(8'h40, 8'h8A);
        lines(20);
        rd(8'h40, 8'h0A);
        wr(16'h0D99);
        lines(20);
        @(posedge core_clk);
        io_control_reg <= 8'h00;
        wr(16'h4083);
        wr(16'h0700);
        lines(20);
        rd(8'h40, 8'h83);
    endtask

    // mid-run reset: outputs and registers fall to zero, then the counter restarts
    task automatic sc_reset();
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        `CHK("scan_line", crtvx_pkg::LINE_RESET, scan_line)
        `CHK("disp_en", 1'b0, disp_en)
        `CHK("vblank", 1'b0, vblank)
        `CHK("start_addr", crtvx_pkg::START_RESET, start_addr)
        `CHK("row_offset", crtvx_pkg::LINE_RESET, row_offset)
        @(posedge core_clk);
        nrst <= 1'b1;
        for (int i = 0; i < 256; i++) rf[i] = 8'h00;
        cur = 0;
        vb = 1'b0;
        exp_sa = crtvx_pkg::START_RESET;
        rd(8'h40, 8'h00);
        lines(3);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // a hang counts as a mismatch and still reaches the one report
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        results();
    end

    initial begin
        for (int i = 0; i < 256; i++) rf[i] = 8'h00;
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        sc_regs();
        sc_std();
        sc_ext();
        sc_start();
        sc_reset();
        results();
    end
endmodule
